// ### crank_cam_defines.vh
// What this block does
// - Watch crank edges arrive while cranking.
// - Count crank teeth every full revolution.
// - Crank request high while running and moving.
// - No cam edge while cranking flags fault.
// - No cam edge while running flags fault.
// - Phase flag must toggle every revolution.
// - Cranking, no crank pulse 2.0 s: fault.
// - Running, no crank pulse 0.1 s: fault.
// - Wrong tooth count per revolution: range fault.
// - Starter on, request off 0.512 s: fault.
// - Request active five times in window: fault.
`ifndef CRANK_CAM_DEFINES_VH
`define CRANK_CAM_DEFINES_VH

// ============================================================
// Timing, in milliseconds or microseconds and derived cycles at 20 MHz
// ============================================================
`define CLK_HZ 20000000
`define CRANK_TMO_MS 2000
`define CRANK_TMO_CYC ((`CRANK_TMO_MS * (`CLK_HZ / 1000)))
`define RUN_TMO_MS 100
`define RUN_TMO_CYC ((`RUN_TMO_MS * (`CLK_HZ / 1000)))
`define REQ_LOW_US 512000
`define REQ_LOW_CYC ((`REQ_LOW_US * (`CLK_HZ / 1000000)))
`define SEG30_MAX_US 77000
`define SEG30_MAX_CYC ((`SEG30_MAX_US * (`CLK_HZ / 1000000)))
`define CAM_TMO_MS 5000
`define CAM_TMO_CYC ((`CAM_TMO_MS * (`CLK_HZ / 1000)))

// ============================================================
// Thresholds and counts
// ============================================================
`define RPM_CRANK_MIN 16'd600
`define RPM_RUN_MIN 16'd1000
`define RPM_REQ_LO 16'd1500
`define RPM_REQ_HI 16'd4000
`define SPEED_REQ_MIN 8'h09
`define VBAT_MIN_MV 16'd6500
`define VBAT_MAX_MV 16'd16000
`define REQ_HIGH_COUNT 3'd5
`define TEETH_PER_REV 8'd34

// ============================================================
// Fault vector bit positions
// ============================================================
`define F_CRANK_OPEN 0
`define F_CRANK_RANGE 1
`define F_REQ_HIGH 2
`define F_REQ_LOW 3
`define F_CAM_OPEN 4
`define F_PHASE 5
`define F_WIDTH 6

`endif

// ### crank_cam_timer.v
`timescale 1ns/100ps
// ============================================================
// Timeout counter: restarts on kick or when disabled
// ============================================================
module crank_cam_timer #(
    parameter [31:0] LIMIT = 32'd100
) (
    // Clock and reset
    input wire sys_clk_i,
    input wire rst_b_i,
    // Control
    input wire enable_i,
    input wire kick_i,
    // Result
    output reg expired_o
);

reg [31:0] count_reg; // Cycles since last kick

// Counter saturates at LIMIT - 1 so it never wraps into a false pass
always @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
        count_reg <= 32'h0;
        expired_o <= 1'b0;
    end else if (!enable_i || kick_i) begin
        count_reg <= 32'h0;
        expired_o <= 1'b0;
    end else if (count_reg >= LIMIT - 32'h1) begin
        expired_o <= 1'b1;
    end else begin
        count_reg <= count_reg + 32'h1;
    end
end

endmodule // crank_cam_timer

// ### crank_cam_signal_monitor.v
`timescale 1ns/100ps
`include "crank_cam_defines.vh"
module crank_cam_signal_monitor #(
    parameter [31:0] CRANK_TMO = `CRANK_TMO_CYC,
    parameter [31:0] RUN_TMO = `RUN_TMO_CYC,
    parameter [31:0] REQ_LOW_TMO = `REQ_LOW_CYC,
    parameter [31:0] SEG30_MAX = `SEG30_MAX_CYC,
    parameter [31:0] CAM_TMO = `CAM_TMO_CYC
) (
    // Clock and reset
    input wire sys_clk_i,
    input wire rst_b_i,
    // Sensor pins (asynchronous)
    input wire crank_position_sensor_i,
    input wire cam_position_sensor_i,
    input wire gap_tooth_i,
    input wire crank_request_i,
    input wire starter_relay_i,
    // Engine state from controller logic
    input wire cranking_i,
    input wire [15:0] engine_rpm_i,
    input wire [7:0] vehicle_speed_i,
    input wire [15:0] battery_mv_i,
    // Fault clear, one bit per flag
    input wire [5:0] fault_clear_i,
    // Status
    output reg [5:0] fault_flags_o,
    output reg fault_indicator_lamp_o
);

// ============================================================
// Input synchronisers: three stages, change once 2nd and 3rd agree
// ============================================================
reg [2:0] crank_sync_reg;
reg [2:0] cam_sync_reg;
reg [2:0] gap_sync_reg;
reg [2:0] req_sync_reg;
reg [2:0] rly_sync_reg;
reg crank_reg; // Filtered levels
reg cam_reg;
reg gap_reg;
reg req_reg;
reg rly_reg;

// Filter: keep old level while stages disagree
function filt;
    input [2:0] s;
    input old;
    begin
        filt = (s[1] == s[2]) ? s[1] : old;
    end
endfunction

always @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
        crank_sync_reg <= 3'h0;
        cam_sync_reg <= 3'h0;
        gap_sync_reg <= 3'h0;
        req_sync_reg <= 3'h0;
        rly_sync_reg <= 3'h0;
        crank_reg <= 1'b0;
        cam_reg <= 1'b0;
        gap_reg <= 1'b0;
        req_reg <= 1'b0;
        rly_reg <= 1'b0;
    end else begin
        crank_sync_reg <= {crank_sync_reg[1:0], crank_position_sensor_i};
        cam_sync_reg <= {cam_sync_reg[1:0], cam_position_sensor_i};
        gap_sync_reg <= {gap_sync_reg[1:0], gap_tooth_i};
        req_sync_reg <= {req_sync_reg[1:0], crank_request_i};
        rly_sync_reg <= {rly_sync_reg[1:0], starter_relay_i};
        crank_reg <= filt(crank_sync_reg, crank_reg);
        cam_reg <= filt(cam_sync_reg, cam_reg);
        gap_reg <= filt(gap_sync_reg, gap_reg);
        req_reg <= filt(req_sync_reg, req_reg);
        rly_reg <= filt(rly_sync_reg, rly_reg);
    end
end

// Edge detection on the filtered levels only
reg crank_d_reg;
reg cam_d_reg;
reg gap_d_reg;
reg req_d_reg;
wire crank_rise = crank_reg & ~crank_d_reg; // One tooth
wire cam_edge = cam_reg ^ cam_d_reg; // Cam edge, either polarity
wire gap_rise = gap_reg & ~gap_d_reg; // Missing-tooth marker
wire req_rise = req_reg & ~req_d_reg; // Request becoming active

always @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
        crank_d_reg <= 1'b0;
        cam_d_reg <= 1'b0;
        gap_d_reg <= 1'b0;
        req_d_reg <= 1'b0;
    end else begin
        crank_d_reg <= crank_reg;
        cam_d_reg <= cam_reg;
        gap_d_reg <= gap_reg;
        req_d_reg <= req_reg;
    end
end

// ============================================================
// Enable windows
// ============================================================
wire vbat_ok = (battery_mv_i >= `VBAT_MIN_MV) && (battery_mv_i <= `VBAT_MAX_MV);
wire crank_en = cranking_i && vbat_ok && (engine_rpm_i >= `RPM_CRANK_MIN);
wire run_en = !cranking_i && (engine_rpm_i >= `RPM_RUN_MIN);
wire range_en = !cranking_i && (engine_rpm_i >= `RPM_CRANK_MIN);
wire moving = vehicle_speed_i >= `SPEED_REQ_MIN;
wire req_win = moving && (engine_rpm_i >= `RPM_REQ_LO) && (engine_rpm_i <= `RPM_REQ_HI);

// ============================================================
// Missing crank pulse, cam edge and request-low timers
// ============================================================
wire crank_tmo; // Cranking timeout hit
wire run_tmo; // Running timeout hit
wire cam_crank_tmo;
wire cam_run_tmo;
wire req_low_tmo;

// Normal edges checked during cranking
crank_cam_timer #(.LIMIT(CRANK_TMO)) u_crank_tmr (
    .sys_clk_i(sys_clk_i),
    .rst_b_i(rst_b_i),
    .enable_i(crank_en),
    .kick_i(crank_rise),
    .expired_o(crank_tmo)
);

// Short running timeout above rpm threshold
crank_cam_timer #(.LIMIT(RUN_TMO)) u_run_tmr (
    .sys_clk_i(sys_clk_i),
    .rst_b_i(rst_b_i),
    .enable_i(run_en),
    .kick_i(crank_rise),
    .expired_o(run_tmo)
);

// Cam edge watchdog while cranking
crank_cam_timer #(.LIMIT(CAM_TMO)) u_cam_crank_tmr (
    .sys_clk_i(sys_clk_i),
    .rst_b_i(rst_b_i),
    .enable_i(cranking_i),
    .kick_i(cam_edge),
    .expired_o(cam_crank_tmo)
);

// Cam edge watchdog in normal running
crank_cam_timer #(.LIMIT(CAM_TMO)) u_cam_run_tmr (
    .sys_clk_i(sys_clk_i),
    .rst_b_i(rst_b_i),
    .enable_i(run_en),
    .kick_i(cam_edge),
    .expired_o(cam_run_tmo)
);

// Starter on with request off, qualified by time
crank_cam_timer #(.LIMIT(REQ_LOW_TMO)) u_req_low_tmr (
    .sys_clk_i(sys_clk_i),
    .rst_b_i(rst_b_i),
    .enable_i(rly_reg && !req_reg),
    .kick_i(1'b0),
    .expired_o(req_low_tmo)
);

// ============================================================
// Per-revolution tooth count, 30 degree time and phase
// ============================================================
reg [7:0] tooth_cnt_reg; // Teeth since last gap
reg [31:0] seg_cnt_reg; // Cycles since last tooth
reg seg_slow_reg; // A tooth interval ran too long this revolution
reg rev_seen_reg; // First gap passed, counts are valid
reg cam_lvl_rev_reg; // Cam level at previous gap
reg tooth_bad_reg; // Count mismatch pulse
reg phase_bad_reg; // No phase toggle pulse

// Count between gaps; the first gap only arms the check
always @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
        tooth_cnt_reg <= 8'h0;
        seg_cnt_reg <= 32'h0;
        seg_slow_reg <= 1'b0;
        rev_seen_reg <= 1'b0;
        cam_lvl_rev_reg <= 1'b0;
        tooth_bad_reg <= 1'b0;
        phase_bad_reg <= 1'b0;
    end else begin
        tooth_bad_reg <= 1'b0;
        phase_bad_reg <= 1'b0;
        // Interval timer; saturates so slow cranking stays marked slow
        if (crank_rise) begin
            seg_cnt_reg <= 32'h0;
        end else if (seg_cnt_reg < SEG30_MAX) begin
            seg_cnt_reg <= seg_cnt_reg + 32'h1;
        end
        if (gap_rise) begin
            // Compare once per revolution
            if (rev_seen_reg && range_en && !seg_slow_reg &&
                tooth_cnt_reg != `TEETH_PER_REV) begin
                tooth_bad_reg <= 1'b1;
            end
            // Phase flag must change every 360 degrees
            if (rev_seen_reg && range_en && cam_reg == cam_lvl_rev_reg) begin
                phase_bad_reg <= 1'b1;
            end
            cam_lvl_rev_reg <= cam_reg;
            rev_seen_reg <= 1'b1;
            tooth_cnt_reg <= 8'h0;
            seg_slow_reg <= 1'b0;
        end else begin
            if (crank_rise && tooth_cnt_reg != 8'hff) begin
                tooth_cnt_reg <= tooth_cnt_reg + 8'h1;
            end
            if (seg_cnt_reg >= SEG30_MAX) begin
                seg_slow_reg <= 1'b1;
            end
        end
    end
end

// ============================================================
// Crank request high: count activations inside the window
// ============================================================
reg [2:0] req_cnt_reg; // Activations seen while moving
reg req_high_reg; // Fifth activation pulse

// Any count of five sets the fault, then restarts
always @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
        req_cnt_reg <= 3'h0;
        req_high_reg <= 1'b0;
    end else begin
        req_high_reg <= 1'b0;
        if (req_rise && req_win) begin
            if (req_cnt_reg == `REQ_HIGH_COUNT - 3'd1) begin
                req_high_reg <= 1'b1;
                req_cnt_reg <= 3'h0;
            end else begin
                req_cnt_reg <= req_cnt_reg + 3'h1;
            end
        end
    end
end

// ============================================================
// Sticky fault flags: a new event wins over a clear
// ============================================================
reg [5:0] fault_set; // Events this cycle
always @* begin
    fault_set = 6'h0;
    fault_set[`F_CRANK_OPEN] = crank_tmo | run_tmo;
    fault_set[`F_CRANK_RANGE] = tooth_bad_reg;
    fault_set[`F_REQ_HIGH] = req_high_reg;
    fault_set[`F_REQ_LOW] = req_low_tmo;
    fault_set[`F_CAM_OPEN] = cam_crank_tmo | cam_run_tmo;
    fault_set[`F_PHASE] = phase_bad_reg;
end

// Held until cleared
always @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
        fault_flags_o <= 6'h0;
        fault_indicator_lamp_o <= 1'b0;
    end else begin
        fault_flags_o <= (fault_flags_o & ~fault_clear_i) | fault_set;
        fault_indicator_lamp_o <= |((fault_flags_o & ~fault_clear_i) | fault_set);
    end
end

endmodule // crank_cam_signal_monitor

// ### crank_cam_checker.sv
`timescale 1ns/100ps
// ==========================================
// Port-level checks on the monitor
module crank_cam_checker #(
    parameter [31:0] RUN_TMO = 32'd50
) (
    // Clock and reset
    input wire sys_clk_i,
    input wire rst_b_i,
    // Watched inputs
    input wire crank_position_sensor_i,
    input wire crank_request_i,
    input wire starter_relay_i,
    input wire cranking_i,
    input wire [15:0] engine_rpm_i,
    input wire [7:0] vehicle_speed_i,
    input wire [15:0] battery_mv_i,
    input wire [5:0] fault_clear_i,
    // Watched outputs
    input wire [5:0] fault_flags_o,
    input wire fault_indicator_lamp_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rst_b_i);
    reg crank_q; // Last crank pin level
    reg [31:0] idle_cnt; // Running cycles since the last tooth
    // Count running time with no tooth; margin covers pin latency
    always @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            crank_q <= 1'b0;
            idle_cnt <= 32'h0;
        end else begin
            crank_q <= crank_position_sensor_i;
            if (cranking_i || engine_rpm_i < 16'd1000 || (crank_position_sensor_i && !crank_q)) begin
                idle_cnt <= 32'h0;
            end else begin
                idle_cnt <= idle_cnt + 32'h1;
            end
        end
    end
    AST_RST_ZERO: assert property (disable iff (1'b0)
        $rose(rst_b_i) |-> fault_flags_o == 6'h00) else $error("flags not clear after reset");
    AST_LAMP: assert property (fault_indicator_lamp_o == (|fault_flags_o))
        else $error("lamp disagrees with flags");
    AST_STICKY: assert property (1'b1 |=>
        (($past(fault_flags_o) & ~$past(fault_clear_i)) & ~fault_flags_o) == 6'h00)
        else $error("flag dropped without clear");
    AST_RUN_TMO: assert property (idle_cnt == RUN_TMO + 32'd8 |-> fault_flags_o[0])
        else $error("running crank timeout missed");
    AST_CRANK_EN: assert property ($rose(fault_flags_o[0]) |->
        $past(engine_rpm_i, 2) >= 16'd600 && (!$past(cranking_i, 2) || $past(battery_mv_i, 2) >= 16'd6500))
        else $error("crank missing outside window");
    AST_RANGE_EN: assert property ($rose(fault_flags_o[1]) |-> !$past(cranking_i, 2))
        else $error("tooth fault while cranking");
    AST_PHASE_EN: assert property ($rose(fault_flags_o[5]) |->
        !$past(cranking_i, 2) && $past(engine_rpm_i, 2) >= 16'd600) else $error("phase fault off window");
    AST_REQ_LOW: assert property ($rose(fault_flags_o[3]) |->
        $past(starter_relay_i, 5) && !$past(crank_request_i, 5)) else $error("request low bad cause");
    AST_REQ_HIGH: assert property ($rose(fault_flags_o[2]) |->
        $past(vehicle_speed_i, 2) >= 8'h09 && $past(engine_rpm_i, 2) >= 16'd1500
        && $past(engine_rpm_i, 2) <= 16'd4000) else $error("request high off window");
    // Main scenarios reached
    COV_RANGE: cover property ($rose(fault_flags_o[1]));
    COV_PHASE: cover property ($rose(fault_flags_o[5]));
    COV_REQ: cover property ($rose(fault_flags_o[2]));
endmodule // crank_cam_checker

bind crank_cam_signal_monitor crank_cam_checker #(.RUN_TMO(RUN_TMO)) crank_cam_checker_i (
    .sys_clk_i, .rst_b_i, .crank_position_sensor_i, .crank_request_i, .starter_relay_i,
    .cranking_i, .engine_rpm_i, .vehicle_speed_i, .battery_mv_i, .fault_clear_i,
    .fault_flags_o, .fault_indicator_lamp_o);

// ### crank_cam_sensors.sv
`timescale 1ns/100ps
// ==========================================
// Crank wheel and cam sensor model
module crank_cam_sensors (
    // Clock
    input wire logic sys_clk_i,
    // Control
    input wire logic run_i,
    input wire logic [7:0] teeth_i,
    input wire logic cam_tgl_i,
    // Sensor pins
    output logic crank_o,
    output logic gap_o,
    output logic cam_o
);
    // One revolution per pass; tooth count read at its start
    initial begin
        crank_o = 1'b0;
        gap_o = 1'b0;
        cam_o = 1'b0;
        forever begin
            @(posedge sys_clk_i);
            if (run_i) begin
                repeat (teeth_i) begin
                    crank_o <= 1'b1;
                    repeat (4) @(posedge sys_clk_i);
                    crank_o <= 1'b0;
                    repeat (4) @(posedge sys_clk_i);
                end
                // Gap marker; cam level flips once a turn when healthy
                gap_o <= 1'b1;
                if (cam_tgl_i) begin
                    cam_o <= ~cam_o;
                end
                repeat (4) @(posedge sys_clk_i);
                gap_o <= 1'b0;
                repeat (12) @(posedge sys_clk_i);
            end
        end
    end
endmodule // crank_cam_sensors

// ### testbench.sv
`timescale 1ns/100ps
`define CHK(a, e) begin #1; tests_run++; if ((a) !== (e)) begin n_mismatch++; \
    $display("FAIL %0t got %h exp %h", $time, a, e); end end
// ==========================================
// Monitor testbench
module testbench;
    logic sys_clk_i, rst_b_i, crank_request_i, starter_relay_i, cranking_i;
    logic [15:0] engine_rpm_i, battery_mv_i;
    logic [7:0] vehicle_speed_i, teeth;
    logic [5:0] fault_clear_i;
    logic run, cam_tgl;
    wire crank_position_sensor_i, cam_position_sensor_i, gap_tooth_i;
    wire [5:0] fault_flags_o;
    wire fault_indicator_lamp_o;
    int n_mismatch = 0;
    int tests_run = 0;
    // Short timeouts keep the run brief
    crank_cam_signal_monitor #(.CRANK_TMO(32'd200), .RUN_TMO(32'd50), .REQ_LOW_TMO(32'd100),
        .SEG30_MAX(32'd40), .CAM_TMO(32'd1000)) crank_cam_signal_monitor_i (
        .sys_clk_i, .rst_b_i, .crank_position_sensor_i, .cam_position_sensor_i, .gap_tooth_i,
        .crank_request_i, .starter_relay_i, .cranking_i, .engine_rpm_i, .vehicle_speed_i,
        .battery_mv_i, .fault_clear_i, .fault_flags_o, .fault_indicator_lamp_o);
    crank_cam_sensors crank_cam_sensors_i (.sys_clk_i, .run_i(run), .teeth_i(teeth),
        .cam_tgl_i(cam_tgl), .crank_o(crank_position_sensor_i), .gap_o(gap_tooth_i),
        .cam_o(cam_position_sensor_i));
    task cyc(input int n);
        repeat (n) @(posedge sys_clk_i);
    endtask
    // Clear held for two cycles, because a timeout whose enable has just dropped
    // still stands for one cycle, and an event wins over a clear in that cycle
    task clr;
        fault_clear_i <= 6'h3f;
        cyc(2);
        fault_clear_i <= 6'h00;
        cyc(2);
    endtask
    task stop_test;
        if (n_mismatch == 0 && tests_run > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // Healthy wheel while running: nothing flags
    task t_run_ok;
        engine_rpm_i <= 16'd2000;
        teeth <= 8'd34;
        cam_tgl <= 1'b1;
        run <= 1'b1;
        cyc(900);
        `CHK(fault_flags_o, 6'h00)
        `CHK(fault_indicator_lamp_o, 1'b0)
    endtask
    // One tooth short per turn, then clear
    task t_teeth;
        teeth <= 8'd33;
        cyc(900);
        `CHK(fault_flags_o, 6'h02)
        cyc(1);
        teeth <= 8'd34;
        cyc(600);
        clr;
        `CHK(fault_flags_o, 6'h00)
    endtask
    // Cam stuck, then wheel stops
    task t_phase;
        cam_tgl <= 1'b0;
        cyc(900);
        `CHK(fault_flags_o & 6'h22, 6'h20)
        cyc(1);
        run <= 1'b0;
        cyc(400);
        `CHK(fault_flags_o[0], 1'b1)
        cyc(1100);
        `CHK(fault_flags_o[4], 1'b1)
    endtask
    // Cranking with no teeth: low battery blocks the check
    task t_crank;
        cranking_i <= 1'b1;
        engine_rpm_i <= 16'd700;
        battery_mv_i <= 16'd5000;
        clr;
        cyc(260);
        `CHK(fault_flags_o[0], 1'b0)
        cyc(1);
        battery_mv_i <= 16'd12000;
        cyc(230);
        `CHK(fault_flags_o[0], 1'b1)
        cyc(560);
        `CHK(fault_flags_o[4], 1'b1)
    endtask
    // Starter on with no request
    task t_req_low;
        cyc(1);
        cranking_i <= 1'b0;
        engine_rpm_i <= 16'h0000;
        starter_relay_i <= 1'b1;
        clr;
        cyc(115);
        `CHK(fault_flags_o, 6'h08)
        cyc(1);
        starter_relay_i <= 1'b0;
        // Relay level needs the pin latency to drop before the timer lets go
        cyc(6);
        clr;
        `CHK(fault_flags_o, 6'h00)
    endtask
    task pulse(input int n);
        repeat (n) begin
            crank_request_i <= 1'b1;
            cyc(8);
            crank_request_i <= 1'b0;
            cyc(8);
        end
    endtask
    // Two requests standing still, then five while moving
    task t_req_high;
        engine_rpm_i <= 16'd2000;
        pulse(2);
        vehicle_speed_i <= 8'd20;
        pulse(4);
        `CHK(fault_flags_o[2], 1'b0)
        cyc(1);
        pulse(1);
        `CHK(fault_flags_o[2], 1'b1)
        `CHK(fault_indicator_lamp_o, 1'b1)
    endtask
    // Clock
    initial begin
        sys_clk_i = 1'b0;
        forever #25 sys_clk_i = ~sys_clk_i;
    end
    // Main sequence
    initial begin
        {rst_b_i, crank_request_i, starter_relay_i, cranking_i, run, cam_tgl} = 6'h00;
        {engine_rpm_i, battery_mv_i, vehicle_speed_i, teeth} = 48'h0;
        fault_clear_i = 6'h00;
        cyc(3);
        rst_b_i <= 1'b1;
        cyc(1);
        `CHK(fault_flags_o, 6'h00)
        t_run_ok;
        t_teeth;
        t_phase;
        t_crank;
        t_req_low;
        t_req_high;
        stop_test;
    end
    // Watchdog, about three times the expected run
    initial begin
        #1000000;
        n_mismatch++;
        stop_test;
    end
endmodule // testbench
